// file: pkg/gdcd_pkg.sv
// Purpose: shared constants and types of the bus command decoder
// Assumes: bytes arrive already accepted by an external acceptor handshake
// Notes: command codes compare on seven bits; the top data line is ignored
package gdcd_pkg;

  // multiline command codes, seven bits
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3F;
  localparam logic [6:0] CMD_UNTALK = 7'h5F;

  // address groups: top two bits of the seven-bit code select the group
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [1:0] GRP_SECONDARY = 2'h3;
  localparam int GRP_POS = 5;
  localparam int ADDR_WIDTH = 5;

  // reset values of the interface state
  localparam logic RST_REMOTE = 1'h0;
  localparam logic RST_LOCKOUT = 1'h0;
  localparam logic RST_SPOLL = 1'h0;
  localparam logic RST_SRQ = 1'h0;

  // one-hot class of an accepted byte
  typedef enum logic [13:0] {
    CLS_NONE = 14'h0001,
    CLS_GTL = 14'h0002,
    CLS_SDC = 14'h0004,
    CLS_GET = 14'h0008,
    CLS_LLO = 14'h0010,
    CLS_DCL = 14'h0020,
    CLS_SPE = 14'h0040,
    CLS_SPD = 14'h0080,
    CLS_MLA = 14'h0100,
    CLS_UNL = 14'h0200,
    CLS_MTA = 14'h0400,
    CLS_OTA = 14'h0800,
    CLS_UNT = 14'h1000,
    CLS_DATA = 14'h2000
  } gdcd_cls_t;

  typedef enum logic [1:0] {
    LSN_IDLE = 2'h1,
    LSN_ACTIVE = 2'h2
  } gdcd_lsn_t;

  typedef enum logic [1:0] {
    TLK_IDLE = 2'h1,
    TLK_ACTIVE = 2'h2
  } gdcd_tlk_t;

  // bus lines after sampling, true-high
  typedef struct packed {
    logic atn;
    logic ifc;
    logic ren;
    logic eoi;
    logic strobe;
    logic [7:0] dio;
  } gdcd_bus_t;

  // data byte handed to the command parser
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } gdcd_rx_t;

  function automatic logic [6:0] cmdCode(input logic [7:0] dio);
    cmdCode = dio[6:0];
  endfunction

endpackage

// file: sim/gdcd_ctl_model.sv
// Purpose: bus controller model that drives the low-true lines and byte strobes
// Assumes: drives just after the falling clock edge
// Notes: released data lines show the inverse of the last byte, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module gdcd_ctl_model (
  // clock
  input wire logic core_clk,
  // bus lines, low-true
  output logic atnN,
  output logic ifcN,
  output logic renN,
  output logic eoiN,
  output logic [7:0] dioN,
  // acceptor handshake done
  output logic byteStrobe
);
  initial
  begin
    atnN = 1'h1;
    ifcN = 1'h1;
    renN = 1'h1;
    eoiN = 1'h1;
    dioN = 8'hFF;
    byteStrobe = 1'h0;
  end

  // only this model drives attention, clear and remote enable
  task automatic send(input logic atn, input logic [7:0] b, input logic last);
    @(negedge core_clk);
    atnN <= ~atn;
    dioN <= ~b;
    eoiN <= ~last;
    byteStrobe <= 1'h1;
    @(negedge core_clk);
    byteStrobe <= 1'h0;
    dioN <= b;
    eoiN <= 1'h1;
  endtask

  task automatic lines(input logic ifc, input logic ren);
    @(negedge core_clk);
    ifcN <= ~ifc;
    renN <= ~ren;
  endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Purpose: self-checking bench of the bus command decoder
// Assumes: device address 16; inputs change on the falling edge
// Notes: pulses are counted on the rising edge so short outputs are never missed
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk, rstn, atnN, ifcN, renN, eoiN, byteStrobe;
  logic [7:0] dioN;
  logic txLastByte, statusByteSent, serviceReq, lockOnRemote, gtlReleasesLock;
  logic [4:0] myAddr;
  logic srqOut, srqOeN, eoiOut, eoiOeN, listenerActive, talkerActive, serialPollMode;
  logic statusByteSel, remoteMode, localLockout, panelLocked, devClear, trigger;
  gdcd_pkg::gdcd_rx_t rxData;
  logic [7:0] lastRx = 8'h00;
  logic lastEnd = 1'h0;
  int mismatches = 0, check_count = 0, cycles = 0, nClr = 0, nTrig = 0, nRx = 0;

  gdcd_ctl_model ctl (.core_clk(core_clk), .atnN(atnN), .ifcN(ifcN), .renN(renN),
    .eoiN(eoiN), .dioN(dioN), .byteStrobe(byteStrobe));
  gdcd_top dut (.core_clk(core_clk), .rstn(rstn), .atnN(atnN), .ifcN(ifcN), .renN(renN),
    .eoiN(eoiN), .dioN(dioN), .byteStrobe(byteStrobe), .txLastByte(txLastByte),
    .statusByteSent(statusByteSent), .myAddr(myAddr), .serviceReq(serviceReq),
    .lockOnRemote(lockOnRemote), .gtlReleasesLock(gtlReleasesLock), .srqOut(srqOut),
    .srqOeN(srqOeN), .eoiOut(eoiOut), .eoiOeN(eoiOeN), .listenerActive(listenerActive),
    .talkerActive(talkerActive), .serialPollMode(serialPollMode),
    .statusByteSel(statusByteSel), .remoteMode(remoteMode), .localLockout(localLockout),
    .panelLocked(panelLocked), .devClear(devClear), .trigger(trigger), .rxData(rxData));

  initial
  begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (devClear === 1'h1) nClr <= nClr + 1;
    if (trigger === 1'h1) nTrig <= nTrig + 1;
    if (rxData.valid === 1'h1)
    begin
      nRx <= nRx + 1;
      lastRx <= rxData.data;
      lastEnd <= rxData.last;
    end
  end

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0b seen %0b", what, exp, got);
    end
  endtask

  task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // covers the two-stage pipeline plus the extra edge of the role outputs
  task automatic settle();
    repeat (4) @(negedge core_clk);
  endtask

  task automatic cmd(input logic [7:0] b);
    ctl.send(1'h1, b, 1'h0);
    settle();
  endtask

  task automatic t_reset();
    check_bit("srqOeN", 1'h1, srqOeN);
    check_bit("eoiOeN", 1'h1, eoiOeN);
    check_bit("srqOut", 1'h0, srqOut);
    check_bit("eoiOut", 1'h0, eoiOut);
    check_bit("listener", 1'h0, listenerActive);
    check_bit("remote", 1'h0, remoteMode);
  endtask

  task automatic t_listen();
    cmd(8'h3F);
    ctl.send(1'h0, 8'h2A, 1'h0);
    settle();
    check_val("rx count idle", 8'h00, 8'(nRx));
    cmd(8'hB0);
    check_bit("listener", 1'h1, listenerActive);
    ctl.send(1'h0, 8'h2A, 1'h0);
    ctl.send(1'h0, 8'h52, 1'h1);
    settle();
    check_val("rx count", 8'h02, 8'(nRx));
    check_val("rx data", 8'h52, lastRx);
    check_bit("rx last", 1'h1, lastEnd);
  endtask

  task automatic t_addressed();
    cmd(8'h04);
    check_val("clear count", 8'h01, 8'(nClr));
    cmd(8'h08);
    check_val("trigger count", 8'h01, 8'(nTrig));
    cmd(8'h05);
    cmd(8'h15);
    cmd(8'h09);
    cmd(8'h70);
    check_val("clear after ignored", 8'h01, 8'(nClr));
    check_val("rx after commands", 8'h02, 8'(nRx));
    check_bit("listener kept", 1'h1, listenerActive);
    cmd(8'h3F);
    check_bit("listener off", 1'h0, listenerActive);
    cmd(8'h04);
    cmd(8'h08);
    check_val("clear unaddressed", 8'h01, 8'(nClr));
    check_val("trigger unaddressed", 8'h01, 8'(nTrig));
  endtask

  task automatic t_remote();
    lockOnRemote = 1'h1;
    gtlReleasesLock = 1'h1;
    ctl.lines(1'h0, 1'h1);
    settle();
    check_bit("remote", 1'h1, remoteMode);
    check_bit("panel", 1'h1, panelLocked);
    cmd(8'h11);
    check_bit("lockout", 1'h1, localLockout);
    cmd(8'h14);
    check_val("device clear", 8'h02, 8'(nClr));
    cmd(8'h30);
    cmd(8'h01);
    check_bit("remote after local", 1'h0, remoteMode);
    check_bit("lockout released", 1'h0, localLockout);
    check_bit("panel released", 1'h0, panelLocked);
    ctl.lines(1'h0, 1'h0);
  endtask

  task automatic t_talk();
    cmd(8'h50);
    check_bit("talker", 1'h1, talkerActive);
    check_bit("listener kept", 1'h1, listenerActive);
    cmd(8'h41);
    check_bit("other talker", 1'h0, talkerActive);
    cmd(8'h50);
    cmd(8'h5F);
    check_bit("untalk", 1'h0, talkerActive);
  endtask

  task automatic t_poll();
    cmd(8'h50);
    serviceReq = 1'h1;
    @(negedge core_clk);
    serviceReq = 1'h0;
    check_bit("srq set", 1'h0, srqOeN);
    cmd(8'h18);
    check_bit("poll mode", 1'h1, serialPollMode);
    check_bit("status select", 1'h1, statusByteSel);
    check_bit("srq pending", 1'h0, srqOeN);
    statusByteSent = 1'h1;
    @(negedge core_clk);
    statusByteSent = 1'h0;
    check_bit("srq serviced", 1'h1, srqOeN);
    cmd(8'h19);
    check_bit("poll off", 1'h0, serialPollMode);
  endtask

  task automatic t_eoi();
    ctl.send(1'h0, 8'h0A, 1'h0);
    settle();
    txLastByte = 1'h1;
    @(negedge core_clk);
    check_bit("eoi drive", 1'h0, eoiOeN);
    check_bit("eoi level", 1'h0, eoiOut);
    txLastByte = 1'h0;
    settle();
    check_bit("eoi release", 1'h1, eoiOeN);
  endtask

  task automatic t_ifc();
    cmd(8'h30);
    cmd(8'h50);
    ctl.lines(1'h1, 1'h0);
    settle();
    ctl.lines(1'h0, 1'h0);
    check_bit("ifc listener", 1'h0, listenerActive);
    check_bit("ifc talker", 1'h0, talkerActive);
  endtask

  initial
  begin
    rstn = 1'h0;
    txLastByte = 1'h0;
    statusByteSent = 1'h0;
    serviceReq = 1'h0;
    lockOnRemote = 1'h0;
    gtlReleasesLock = 1'h0;
    myAddr = 5'h10;
    repeat (6) @(negedge core_clk);
    t_reset();
    rstn = 1'h1;
    // the ceiling counts as a mismatch and ends in the same report
    fork
      begin
        t_listen();
        t_addressed();
        t_remote();
        t_talk();
        t_poll();
        t_eoi();
        t_ifc();
      end
      begin
        wait (cycles == 3000);
        mismatches++;
      end
    join_any
    close_out();
  end
endmodule
`default_nettype wire

// file: verilog/gdcd_cmd_classify.sv
// Purpose: classifies one accepted byte against the command table
// Assumes: myAddr is in 0 to 30
// Notes: unlisten and untalk are checked before the address groups
`timescale 1ns/1ns
`default_nettype none
module gdcd_cmd_classify (
  // sampled bus
  input wire gdcd_pkg::gdcd_bus_t bus,
  // own primary address
  input wire logic [4:0] myAddr,
  // class of the byte
  output gdcd_pkg::gdcd_cls_t cls
);

  logic [6:0] code;
  logic [1:0] grp;
  logic [4:0] low;

  always_comb
  begin
    code = gdcd_pkg::cmdCode(bus.dio);
    grp = code[6:gdcd_pkg::GRP_POS];
    low = code[gdcd_pkg::ADDR_WIDTH-1:0];
    cls = gdcd_pkg::CLS_NONE;
    if (!bus.strobe)
      cls = gdcd_pkg::CLS_NONE;
    else if (!bus.atn)
      cls = gdcd_pkg::CLS_DATA;
    else if (code == gdcd_pkg::CMD_UNLISTEN)
      cls = gdcd_pkg::CLS_UNL;
    else if (code == gdcd_pkg::CMD_UNTALK)
      cls = gdcd_pkg::CLS_UNT;
    else if (grp == gdcd_pkg::GRP_LISTEN)
      cls = (low == myAddr) ? gdcd_pkg::CLS_MLA : gdcd_pkg::CLS_NONE;
    else if (grp == gdcd_pkg::GRP_TALK)
      cls = (low == myAddr) ? gdcd_pkg::CLS_MTA : gdcd_pkg::CLS_OTA;
    else if (grp == gdcd_pkg::GRP_SECONDARY)
      cls = gdcd_pkg::CLS_NONE;
    else
    begin
      case (code)
        gdcd_pkg::CMD_GTL: cls = gdcd_pkg::CLS_GTL;
        gdcd_pkg::CMD_SDC: cls = gdcd_pkg::CLS_SDC;
        gdcd_pkg::CMD_GET: cls = gdcd_pkg::CLS_GET;
        gdcd_pkg::CMD_LLO: cls = gdcd_pkg::CLS_LLO;
        gdcd_pkg::CMD_DCL: cls = gdcd_pkg::CLS_DCL;
        gdcd_pkg::CMD_SPE: cls = gdcd_pkg::CLS_SPE;
        gdcd_pkg::CMD_SPD: cls = gdcd_pkg::CLS_SPD;
        default: cls = gdcd_pkg::CLS_NONE;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verilog/gdcd_line_sampler.sv
// Purpose: registers the low-true bus lines and turns them true-high
// Assumes: pins and strobe are synchronous to core_clk
// Notes: input only; the device never drives the controller's lines
`timescale 1ns/1ns
`default_nettype none
module gdcd_line_sampler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus pins, low-true
  input wire logic atnN,
  input wire logic ifcN,
  input wire logic renN,
  input wire logic eoiN,
  input wire logic [7:0] dioN,
  // byte accepted by the acceptor handshake, true-high
  input wire logic byteStrobe,
  // sampled lines
  output gdcd_pkg::gdcd_bus_t bus
);

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      bus <= '0;
    end
    else
    begin
      bus.atn <= ~atnN;
      bus.ifc <= ~ifcN;
      bus.ren <= ~renN;
      bus.eoi <= ~eoiN;
      bus.dio <= ~dioN;
      bus.strobe <= byteStrobe;
    end
  end

endmodule
`default_nettype wire

// file: verilog/gdcd_top.sv
// Purpose: device-side decoder of bus commands, addressing and remote state
// Assumes: an external acceptor handshake delivers each byte with byteStrobe
// Notes: parallel poll, take control and secondary addresses are not decoded
// Functional notes
// - assert service request and hold it until a serial poll services it
// - remote enable true moves device to remote; lock panel if configured
// - sender marks the final byte with end-or-identify; receiver detects end
// - interface clear returns talker and listener to idle unaddressed
// - bytes under attention are interface commands, never device data
// - local lockout 0x11 disables local key and panel, no addressing needed
// - device clear 0x14 returns device to default state, unaddressed
// - 0x18 enters serial poll mode, 0x19 leaves; talker then sends status
// - addressed commands act only while addressed to listen
// - selective clear 0x04 acts like device clear when listening
// - go-to-local 0x01 leaves remote when listening; may release lockout
// - group execute trigger 0x08 starts triggered action when listening
// - primary address OR 0x20 is the listen address; makes device listener
// - primary address OR 0x40 is the talk address; makes device talker
// - secondary address bytes 0x60 to 0x7F are ignored
// - unlisten 0x3F drops listener addressing to listener idle
// - untalk 0x5F drops talker addressing to talker idle
// - data bytes with attention false go to the parser when listening
// - parallel poll configure, unconfigure and take control are ignored
// - all bus lines are low-true; invert on sampling and driving
// - bytes move by interlocked handshake outside this block
`timescale 1ns/1ns
`default_nettype none
module gdcd_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bus management pins, low-true, receive only
  input wire logic atnN,
  input wire logic ifcN,
  input wire logic renN,
  input wire logic eoiN,
  input wire logic [7:0] dioN,
  // acceptor handshake side
  input wire logic byteStrobe,
  // source handshake side
  input wire logic txLastByte,
  input wire logic statusByteSent,
  // device side controls
  input wire logic [4:0] myAddr,
  input wire logic serviceReq,
  input wire logic lockOnRemote,
  input wire logic gtlReleasesLock,
  // open-drain pins, enable low while driving
  output logic srqOut,
  output logic srqOeN,
  output logic eoiOut,
  output logic eoiOeN,
  // interface state
  output logic listenerActive,
  output logic talkerActive,
  output logic serialPollMode,
  output logic statusByteSel,
  output logic remoteMode,
  output logic localLockout,
  output logic panelLocked,
  // events and data to the instrument
  output logic devClear,
  output logic trigger,
  output gdcd_pkg::gdcd_rx_t rxData
);

  gdcd_pkg::gdcd_bus_t bus;
  gdcd_pkg::gdcd_cls_t cls;
  gdcd_pkg::gdcd_lsn_t lsnState;
  gdcd_pkg::gdcd_tlk_t tlkState;
  logic renPrev;
  logic srqPending;
  logic next_srqPending;
  logic next_remote;
  logic next_lockout;
  logic listening;
  logic talking;
  logic pollServiced;

  // the block has no outputs on attention, clear or remote lines
  gdcd_line_sampler sampler (
    .core_clk(core_clk),
    .rstn(rstn),
    .atnN(atnN),
    .ifcN(ifcN),
    .renN(renN),
    .eoiN(eoiN),
    .dioN(dioN),
    .byteStrobe(byteStrobe), // handshake done upstream
    .bus(bus)
  );

  // classifier masks bit 7 and drops secondary and parallel poll codes
  gdcd_cmd_classify classify (
    .bus(bus),
    .myAddr(myAddr),
    .cls(cls)
  );

  assign listening = (lsnState == gdcd_pkg::LSN_ACTIVE);
  assign talking = (tlkState == gdcd_pkg::TLK_ACTIVE);

  // listener function
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      lsnState <= gdcd_pkg::LSN_IDLE;
    else if (bus.ifc)
      lsnState <= gdcd_pkg::LSN_IDLE;
    else
    begin
      case (cls)
        gdcd_pkg::CLS_UNL: lsnState <= gdcd_pkg::LSN_IDLE;
        gdcd_pkg::CLS_MLA: lsnState <= gdcd_pkg::LSN_ACTIVE;
        default: lsnState <= lsnState; // talk addresses leave it alone
      endcase
    end
  end

  // talker function
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      tlkState <= gdcd_pkg::TLK_IDLE;
    else if (bus.ifc)
      tlkState <= gdcd_pkg::TLK_IDLE;
    else
    begin
      case (cls)
        gdcd_pkg::CLS_UNT: tlkState <= gdcd_pkg::TLK_IDLE;
        gdcd_pkg::CLS_OTA: tlkState <= gdcd_pkg::TLK_IDLE;
        gdcd_pkg::CLS_MTA: tlkState <= gdcd_pkg::TLK_ACTIVE;
        default: tlkState <= tlkState;
      endcase
    end
  end

  // serial poll mode
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      serialPollMode <= gdcd_pkg::RST_SPOLL;
    else if (bus.ifc)
      serialPollMode <= gdcd_pkg::RST_SPOLL;
    else if (cls == gdcd_pkg::CLS_SPE)
      serialPollMode <= 1'h1;
    else if (cls == gdcd_pkg::CLS_SPD)
      serialPollMode <= 1'h0;
  end

  // remote and lockout; dropping remote enable always returns to local
  always_comb
  begin
    next_remote = remoteMode;
    next_lockout = localLockout;
    if (!bus.ren)
    begin
      next_remote = 1'h0;
      next_lockout = 1'h0;
    end
    else
    begin
      if (cls == gdcd_pkg::CLS_GTL && listening)
        next_remote = 1'h0;
      else if (!renPrev || cls == gdcd_pkg::CLS_MLA)
        next_remote = 1'h1;
      if (cls == gdcd_pkg::CLS_LLO)
        next_lockout = 1'h1;
      else if (cls == gdcd_pkg::CLS_GTL && listening && gtlReleasesLock)
        next_lockout = 1'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      renPrev <= 1'h0;
      remoteMode <= gdcd_pkg::RST_REMOTE;
      localLockout <= gdcd_pkg::RST_LOCKOUT;
      panelLocked <= 1'h0;
    end
    else
    begin
      renPrev <= bus.ren;
      remoteMode <= next_remote;
      localLockout <= next_lockout;
      // lockout keeps the panel locked even while back in local
      panelLocked <= next_lockout | (next_remote & lockOnRemote);
    end
  end

  // one-cycle events to the instrument
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      devClear <= 1'h0;
      trigger <= 1'h0;
    end
    else
    begin
      devClear <= (cls == gdcd_pkg::CLS_DCL)
        | (cls == gdcd_pkg::CLS_SDC && listening);
      trigger <= (cls == gdcd_pkg::CLS_GET && listening);
    end
  end

  // data bytes never come from command traffic
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rxData <= '0;
    else
    begin
      rxData.valid <= (cls == gdcd_pkg::CLS_DATA) && listening;
      if (cls == gdcd_pkg::CLS_DATA && listening)
      begin
        rxData.data <= bus.dio;
        rxData.last <= bus.eoi;
      end
    end
  end

  // service request: new request wins over a clear in the same cycle
  assign pollServiced = statusByteSent && serialPollMode && talking;

  always_comb
  begin
    next_srqPending = srqPending;
    if (serviceReq)
      next_srqPending = 1'h1;
    else if (pollServiced)
      next_srqPending = 1'h0;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      srqPending <= gdcd_pkg::RST_SRQ;
      srqOut <= 1'h0;
      srqOeN <= 1'h1;
    end
    else
    begin
      srqPending <= next_srqPending;
      srqOut <= 1'h0;
      srqOeN <= ~next_srqPending; // low-true drive
    end
  end

  // status outputs and end marker as talker
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      listenerActive <= 1'h0;
      talkerActive <= 1'h0;
      statusByteSel <= 1'h0;
      eoiOut <= 1'h0;
      eoiOeN <= 1'h1;
    end
    else
    begin
      listenerActive <= listening;
      talkerActive <= talking;
      statusByteSel <= talking && serialPollMode;
      eoiOut <= 1'h0;
      // status byte is a single byte, so no end marker in serial poll
      eoiOeN <= ~(talking && !serialPollMode && !bus.atn && txLastByte);
    end
  end

  a_ifc_idle_roles: assert property (@(posedge core_clk) disable iff (!rstn)
    bus.ifc |=> !listening && !talking ##1 !listenerActive && !talkerActive)
    else $error("interface clear did not idle talker and listener");

  a_llo_sets_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_LLO && bus.ren) |=> localLockout && panelLocked)
    else $error("local lockout not applied");

  a_clear_event: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_DCL || (cls == gdcd_pkg::CLS_SDC && listening))
      |=> devClear ##1 (!devClear || $past(cls) == gdcd_pkg::CLS_DCL
        || ($past(cls) == gdcd_pkg::CLS_SDC && $past(listening))))
    else $error("device clear pulse missing or stretched");

  a_spoll_enter: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_SPE && !bus.ifc && talking)
      |=> serialPollMode ##1 (statusByteSel || !talking))
    else $error("serial poll enable not taken");

  a_acg_needs_listen: assert property (@(posedge core_clk) disable iff (!rstn)
    (trigger || (devClear && $past(cls) == gdcd_pkg::CLS_SDC)) |-> $past(listening))
    else $error("addressed command acted on while not listening");

  a_gtl_local: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_GTL && listening) |=> !remoteMode)
    else $error("go to local did not leave remote");

  a_mla_listen: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_MLA && !bus.ifc) |-> ##2 listenerActive)
    else $error("own listen address not taken");

  a_mta_talk: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_MTA && !bus.ifc) |=> talking && $stable(lsnState))
    else $error("own talk address not taken");

  a_unl_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_UNL) |=> !listening)
    else $error("unlisten did not idle listener");

  a_unt_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (cls == gdcd_pkg::CLS_UNT) |=> !talking)
    else $error("untalk did not idle talker");

  a_data_pass: assert property (@(posedge core_clk) disable iff (!rstn)
    rxData.valid |-> $past(bus.strobe) && !$past(bus.atn) && $past(listening))
    else $error("data passed under attention or unaddressed");

  a_srq_held: assert property (@(posedge core_clk) disable iff (!rstn)
    (srqPending && !pollServiced) |=> srqPending && !srqOeN)
    else $error("service request dropped before serial poll");

endmodule
`default_nettype wire
